//--- rtl/spcr_consts.svh
/*
 * Holds the offsets, field positions, reset values and access masks of the
 * switch port configuration register bank.
 * Assumes it is included by its bare name from the design and the bench.
 */
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// Type 1 header offsets.
`define SPCR_OFF_IDENT 12'h000
`define SPCR_OFF_CMD_STATE 12'h004
`define SPCR_OFF_CLASS_REV 12'h008
`define SPCR_OFF_MISC 12'h00c
`define SPCR_OFF_BAR_LO 12'h010
`define SPCR_OFF_BAR_HI 12'h014
`define SPCR_OFF_BUS_NUM 12'h018
`define SPCR_OFF_IO_WIN 12'h01c
`define SPCR_OFF_MEM_WIN 12'h020
`define SPCR_OFF_PF_WIN 12'h024
`define SPCR_OFF_PF_BASE_UP 12'h028
`define SPCR_OFF_PF_LIM_UP 12'h02c
`define SPCR_OFF_IO_UP 12'h030
`define SPCR_OFF_CAP_START 12'h034
`define SPCR_OFF_ROM_UNUSED 12'h038
`define SPCR_OFF_INT_BRIDGE 12'h03c

// Switch configuration offsets.
`define SPCR_OFF_PORT_WIDTH 12'h300
`define SPCR_OFF_VS_UP0 12'h360
`define SPCR_OFF_VS_UP3 12'h36c
`define SPCR_OFF_VS_MEM0 12'h380
`define SPCR_OFF_VS_MEM3 12'h38c
`define SPCR_OFF_PORT_RESET 12'h3a0
`define SPCR_OFF_DOORBELL_SET 12'h3c0
`define SPCR_OFF_DOORBELL_CLR 12'h3c4
`define SPCR_OFF_SCRATCH_STICKY 12'h3c8
`define SPCR_OFF_READ_ZERO 12'h3cc
`define SPCR_OFF_STICKY_STATUS 12'h3d0

// Port width field positions.
`define SPCR_STN0_LSB 0
`define SPCR_STN4_LSB 8
`define SPCR_STN5_LSB 10

// Fixed header values.
`define SPCR_CAP_POINTER 32'h0000_0040
`define SPCR_CLASS_REV_RST 32'h0604_00aa
`define SPCR_IDENT_RST 32'h1234_5678
`define SPCR_CAP_LIST_BIT 32'h0010_0000

// Software-writable masks; all other bits are read-only or reserved.
`define SPCR_CMD_RW_MASK 32'h0000_0547
`define SPCR_STAT_W1C_MASK 32'h8900_0000
`define SPCR_MISC_RW_MASK 32'h0000_00ff
`define SPCR_BAR_LO_RW_MASK 32'hfffe_0000
`define SPCR_BUS_RW_MASK 32'h00ff_ffff
`define SPCR_IO_RW_MASK 32'h0000_f0f0
`define SPCR_MEM_RW_MASK 32'hfff0_fff0
`define SPCR_IO_UP_RW_MASK 32'hffff_ffff
`define SPCR_INT_RW_MASK 32'h0fff_00ff
`define SPCR_PORT_WIDTH_MASK 32'h0000_0f03
`define SPCR_PORT_RESET_MASK 32'h00ff_000f
`define SPCR_VS_MEM_MASK 32'h00ff_000f

// Virtual switch member defaults by strap: 2, 3 and 4 switches.
`define SPCR_VS2_MEM0 32'h0030_000f
`define SPCR_VS2_MEM1 32'h00cf_0000
`define SPCR_VS3_MEM0 32'h0000_000f
`define SPCR_VS3_MEM1 32'h000f_0000
`define SPCR_VS3_MEM2 32'h00f0_0000
`define SPCR_VS4_MEM0 32'h0000_0007
`define SPCR_VS4_MEM1 32'h0003_0008
`define SPCR_VS4_MEM2 32'h0034_0000
`define SPCR_VS4_MEM3 32'h00c8_0000

`endif

//--- rtl/spcr_pkg.sv
/*
 * Types shared by the switch port configuration register bank.
 * Assumes spcr_consts.svh is on the include path.
 */
package spcr_pkg;

    typedef enum logic [1:0] {
        SPCR_W_FOUR_X4 = 2'b00,
        SPCR_W_ONE_X16 = 2'b01,
        SPCR_W_TWO_X8 = 2'b10,
        SPCR_W_X8_TWO_X4 = 2'b11
    } spcr_width_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } spcr_req_t;

    typedef struct packed {
        spcr_width_t stn0;
        spcr_width_t stn4;
        spcr_width_t stn5;
        logic [1:0] vs_count;
    } spcr_strap_t;

endpackage : spcr_pkg

//--- rtl/spcr_regs.sv
/*
 * Configuration register bank of one switch: type 1 header, port width,
 * virtual switch membership and upstream selection, port reset, doorbell.
 * Assumes a single-cycle access port from the management or sideband logic,
 * and straps stable while fundamental reset is low.
 */
`include "spcr_consts.svh"

module spcr_regs (
    // Clock, resets, enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic soft_reset_n,
    input wire logic clk_en,
    // Straps and mode.
    input wire spcr_pkg::spcr_strap_t straps,
    input wire logic mgmt_access,
    // Register access.
    input wire spcr_pkg::spcr_req_t req,
    input wire logic init_wr,
    output logic [31:0] rdata,
    output logic rvalid,
    // Hardware events.
    input wire logic [31:0] status_set,
    input wire logic sticky_err_set,
    input wire logic irq_pending,
    // Configuration outputs.
    output logic [11:0] port_width_out,
    output logic [47:0] lane_owner_first,
    output logic [23:0] port_reset_out,
    output logic doorbell_irq
);

    logic [31:0] ident_q, ident_d;
    logic [31:0] cmd_q, cmd_d;
    logic [31:0] misc_q, misc_d;
    logic [31:0] bar_lo_q, bar_lo_d;
    logic [31:0] bar_hi_q, bar_hi_d;
    logic [31:0] bus_q, bus_d;
    logic [31:0] io_q, io_d;
    logic [31:0] mem_q, mem_d;
    logic [31:0] pf_q, pf_d;
    logic [31:0] pf_bu_q, pf_bu_d;
    logic [31:0] pf_lu_q, pf_lu_d;
    logic [31:0] io_up_q, io_up_d;
    logic [31:0] intb_q, intb_d;
    logic [31:0] pw_q, pw_d;
    logic [31:0] vs_up_q [4];
    logic [31:0] vs_mem_q [4];
    logic [31:0] prst_q, prst_d;
    logic [31:0] db_q, db_d;
    logic [31:0] scr_q, scr_d;
    logic [31:0] sts_q, sts_d;
    logic [31:0] rdata_d;
    logic [31:0] mem_def [4];
    logic [31:0] up_def [4];

    wire logic swr = req.wr;
    wire logic [31:0] wd = req.wdata;
    wire logic [11:0] a = req.addr;
    wire logic init_ok = init_wr & swr;
    wire logic sw_ok = swr & ~init_wr;
    wire logic [1:0] vs_idx = a[3:2];
    wire logic in_up = (a >= `SPCR_OFF_VS_UP0) && (a <= `SPCR_OFF_VS_UP3);
    wire logic in_mem = (a >= `SPCR_OFF_VS_MEM0) && (a <= `SPCR_OFF_VS_MEM3);
    wire logic mgmt_wr = swr & mgmt_access;
    // Strap word laid out as the port width register.
    wire logic [31:0] strap_word = {20'h0, straps.stn5, straps.stn4, 6'h0, straps.stn0};
    wire logic [31:0] db_clear = (sw_ok && a == `SPCR_OFF_DOORBELL_CLR) ? wd : 32'h0;
    wire logic [31:0] sts_clear = (sw_ok && a == `SPCR_OFF_STICKY_STATUS) ? wd : 32'h0;

    // Per-strap member and upstream defaults.
    always_comb
    begin
        unique case (straps.vs_count)
            2'b01:
            begin
                mem_def = '{`SPCR_VS2_MEM0, `SPCR_VS2_MEM1, 32'h0, 32'h0};
                up_def = '{32'd0, 32'd16, 32'd0, 32'd0};
            end
            2'b10:
            begin
                mem_def = '{`SPCR_VS3_MEM0, `SPCR_VS3_MEM1, `SPCR_VS3_MEM2, 32'h0};
                up_def = '{32'd0, 32'd16, 32'd20, 32'd0};
            end
            2'b11:
            begin
                mem_def = '{`SPCR_VS4_MEM0, `SPCR_VS4_MEM1, `SPCR_VS4_MEM2,
                    `SPCR_VS4_MEM3};
                up_def = '{32'd0, 32'd16, 32'd20, 32'd22};
            end
            default:
            begin
                mem_def = '{32'h00ff_000f, 32'h0, 32'h0, 32'h0};
                up_def = '{32'd0, 32'd0, 32'd0, 32'd0};
            end
        endcase
    end

    // Masked next-state terms: read-only bits keep value on software writes.
    function automatic logic [31:0] mw(input logic hit, input logic [31:0] q,
        input logic [31:0] m, input logic [31:0] d);
        mw = hit ? ((q & ~m) | (d & m)) : q;
    endfunction : mw

    assign ident_d = (init_ok && a == `SPCR_OFF_IDENT) ? wd : ident_q;
    assign cmd_d = (mw(sw_ok && a == `SPCR_OFF_CMD_STATE, cmd_q, `SPCR_CMD_RW_MASK, wd)
        & ~(sw_ok && a == `SPCR_OFF_CMD_STATE ? (wd & `SPCR_STAT_W1C_MASK) : 32'h0))
        | (status_set & `SPCR_STAT_W1C_MASK);
    assign misc_d = mw(swr && a == `SPCR_OFF_MISC, misc_q, `SPCR_MISC_RW_MASK, wd);
    assign bar_lo_d = mw(swr && a == `SPCR_OFF_BAR_LO, bar_lo_q, `SPCR_BAR_LO_RW_MASK, wd);
    assign bar_hi_d = mw(swr && a == `SPCR_OFF_BAR_HI, bar_hi_q, 32'hffff_ffff, wd);
    assign bus_d = mw(swr && a == `SPCR_OFF_BUS_NUM, bus_q, `SPCR_BUS_RW_MASK, wd);
    assign io_d = mw(swr && a == `SPCR_OFF_IO_WIN, io_q, `SPCR_IO_RW_MASK, wd);
    assign mem_d = mw(swr && a == `SPCR_OFF_MEM_WIN, mem_q, `SPCR_MEM_RW_MASK, wd);
    assign pf_d = mw(swr && a == `SPCR_OFF_PF_WIN, pf_q, `SPCR_MEM_RW_MASK, wd);
    assign pf_bu_d = mw(swr && a == `SPCR_OFF_PF_BASE_UP, pf_bu_q, 32'hffff_ffff, wd);
    assign pf_lu_d = mw(swr && a == `SPCR_OFF_PF_LIM_UP, pf_lu_q, 32'hffff_ffff, wd);
    assign io_up_d = mw(swr && a == `SPCR_OFF_IO_UP, io_up_q, `SPCR_IO_UP_RW_MASK, wd);
    assign intb_d = mw(swr && a == `SPCR_OFF_INT_BRIDGE, intb_q, `SPCR_INT_RW_MASK, wd);
    assign pw_d = mw(mgmt_wr && a == `SPCR_OFF_PORT_WIDTH, pw_q,
        `SPCR_PORT_WIDTH_MASK, wd);
    assign prst_d = mw(mgmt_wr && a == `SPCR_OFF_PORT_RESET, prst_q,
        `SPCR_PORT_RESET_MASK, wd);
    assign db_d = (db_q & ~db_clear)
        | ((sw_ok && a == `SPCR_OFF_DOORBELL_SET) ? wd : 32'h0);
    assign scr_d = mw(swr && a == `SPCR_OFF_SCRATCH_STICKY, scr_q, 32'hffff_ffff, wd);
    assign sts_d = (sts_q & ~sts_clear) | {31'h0, sticky_err_set};

    // Lane owner first-lane marks: bit set on each port's lowest lane.
    function automatic logic [15:0] first_lanes(input logic [1:0] w);
        unique case (w)
            2'b00: first_lanes = 16'h1111;
            2'b01: first_lanes = 16'h0001;
            2'b10: first_lanes = 16'h0101;
            2'b11: first_lanes = 16'h1101;
        endcase
    endfunction : first_lanes

    // Read mux; reserved and read-zero locations return zero.
    always_comb
    begin
        rdata_d = 32'h0;
        // Switch vectors answer only on the management path.
        if (in_up)
        begin
            rdata_d = mgmt_access ? vs_up_q[vs_idx] : 32'h0;
        end
        else if (in_mem)
        begin
            rdata_d = mgmt_access ? vs_mem_q[vs_idx] : 32'h0;
        end
        else
        begin
            unique case (a)
                `SPCR_OFF_IDENT: rdata_d = ident_q;
                `SPCR_OFF_CMD_STATE: rdata_d = cmd_q | `SPCR_CAP_LIST_BIT
                    | {12'h0, irq_pending & ~cmd_q[10], 19'h0};
                `SPCR_OFF_CLASS_REV: rdata_d = `SPCR_CLASS_REV_RST;
                `SPCR_OFF_MISC: rdata_d = misc_q | 32'h0001_0000;
                `SPCR_OFF_BAR_LO: rdata_d = bar_lo_q;
                `SPCR_OFF_BAR_HI: rdata_d = bar_hi_q;
                `SPCR_OFF_BUS_NUM: rdata_d = bus_q;
                `SPCR_OFF_IO_WIN: rdata_d = io_q | 32'h0000_0101;
                `SPCR_OFF_MEM_WIN: rdata_d = mem_q;
                `SPCR_OFF_PF_WIN: rdata_d = pf_q | 32'h0001_0001;
                `SPCR_OFF_PF_BASE_UP: rdata_d = pf_bu_q;
                `SPCR_OFF_PF_LIM_UP: rdata_d = pf_lu_q;
                `SPCR_OFF_IO_UP: rdata_d = io_up_q;
                `SPCR_OFF_CAP_START: rdata_d = `SPCR_CAP_POINTER;
                `SPCR_OFF_INT_BRIDGE: rdata_d = intb_q | 32'h0000_0100;
                `SPCR_OFF_PORT_WIDTH: rdata_d = mgmt_access ? pw_q : 32'h0;
                `SPCR_OFF_PORT_RESET: rdata_d = mgmt_access ? prst_q : 32'h0;
                `SPCR_OFF_DOORBELL_SET: rdata_d = db_q;
                `SPCR_OFF_DOORBELL_CLR: rdata_d = db_q;
                `SPCR_OFF_SCRATCH_STICKY: rdata_d = scr_q;
                `SPCR_OFF_STICKY_STATUS: rdata_d = sts_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Fundamental reset restores everything, hardware-initialized bits included.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ident_q <= `SPCR_IDENT_RST;
            // Straps are taken on every edge while fundamental reset is low.
            pw_q <= strap_word;
            scr_q <= 32'h0;
            sts_q <= 32'h0;
        end
        else if (clk_en)
        begin
            ident_q <= ident_d;
            pw_q <= pw_d;
            scr_q <= scr_d;
            sts_q <= sts_d;
        end
    end

    // Outputs see the straps directly on the first enabled edge after fundamental reset.
    logic strap_loaded_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            strap_loaded_q <= 1'b0;
        end
        else if (clk_en)
        begin
            strap_loaded_q <= 1'b1;
        end
    end

    logic [31:0] pw_live;
    assign pw_live = strap_loaded_q ? pw_q : strap_word;

    // Soft-resettable registers.
    wire logic any_rst = !reset_n || !soft_reset_n;
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            cmd_q <= 32'h0;
            misc_q <= 32'h0;
            bar_lo_q <= 32'h0;
            bar_hi_q <= 32'h0;
            bus_q <= 32'h0;
            io_q <= 32'h0;
            mem_q <= 32'h0;
            pf_q <= 32'h0;
            pf_bu_q <= 32'h0;
            pf_lu_q <= 32'h0;
            io_up_q <= 32'h0;
            intb_q <= 32'h0;
            prst_q <= 32'h0;
            db_q <= 32'h0;
            rdata <= 32'h0;
            rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            cmd_q <= cmd_d;
            misc_q <= misc_d;
            bar_lo_q <= bar_lo_d;
            bar_hi_q <= bar_hi_d;
            bus_q <= bus_d;
            io_q <= io_d;
            mem_q <= mem_d;
            pf_q <= pf_d;
            pf_bu_q <= pf_bu_d;
            pf_lu_q <= pf_lu_d;
            io_up_q <= io_up_d;
            intb_q <= intb_d;
            prst_q <= prst_d;
            db_q <= db_d;
            rdata <= req.rd ? rdata_d : 32'h0;
            rvalid <= req.rd;
        end
    end

    // Virtual switch vectors and upstream selects.
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            vs_mem_q <= mem_def;
            vs_up_q <= up_def;
        end
        else if (clk_en && mgmt_wr)
        begin
            if (in_mem)
            begin
                vs_mem_q[vs_idx] <= wd & `SPCR_VS_MEM_MASK;
            end
            if (in_up)
            begin
                vs_up_q[vs_idx] <= {27'h0, wd[4:0]};
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            port_width_out <= 12'h0;
            lane_owner_first <= 48'h0;
            port_reset_out <= 24'h0;
            doorbell_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            port_width_out <= pw_live[11:0];
            lane_owner_first <= {first_lanes(pw_live[9:8]), first_lanes(pw_live[11:10]),
                first_lanes(pw_live[1:0])};
            port_reset_out <= {prst_q[23:16], 12'h0, prst_q[3:0]};
            doorbell_irq <= |db_q;
        end
    end

    // Access-type checks, strap defaults and the main scenarios.
    property cap_ptr_p;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && req.rd && a == `SPCR_OFF_CAP_START) |=> rdata == 32'h0000_0040;
    endproperty
    cap_pointer_a: assert property (cap_ptr_p) else $error("cap pointer wrong");
    ident_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && sw_ok && a == `SPCR_OFF_IDENT) |=> $stable(ident_q))
        else $error("ident changed by software");
    ident_init_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && init_ok && a == `SPCR_OFF_IDENT) |=> ident_q == $past(wd))
        else $error("ident not loaded by init path");
    w1c_clear_a: assert property (@(posedge clk) disable iff (any_rst)
        (clk_en && sw_ok && a == `SPCR_OFF_STICKY_STATUS && wd[0] && !sticky_err_set)
        |=> !sts_q[0]) else $error("sticky status not cleared");
    w1c_set_wins_a: assert property (@(posedge clk) disable iff (any_rst)
        (clk_en && status_set[31]) |=> cmd_q[31])
        else $error("status event lost");
    w1c_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && sts_q[0] && !(sw_ok && a == `SPCR_OFF_STICKY_STATUS && wd[0]))
        |=> sts_q[0]) else $error("status lost");
    sticky_soft_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!soft_reset_n && !(clk_en && swr)) |=> $stable(scr_q))
        else $error("sticky changed by soft reset");
    doorbell_set_a: assert property (@(posedge clk) disable iff (any_rst)
        (clk_en && sw_ok && a == `SPCR_OFF_DOORBELL_SET && wd != 32'h0) ##1 clk_en
        |=> doorbell_irq) else $error("doorbell not raised");
    read_zero_a: assert property (@(posedge clk) disable iff (any_rst)
        (clk_en && req.rd && a == `SPCR_OFF_READ_ZERO) |=> rdata == 32'h0)
        else $error("read zero returned data");
    width_mgmt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && swr && !mgmt_access && a == `SPCR_OFF_PORT_WIDTH) |=> $stable(pw_q))
        else $error("width written off management path");
    width_strap_a: assert property (@(posedge clk)
        !reset_n |=> pw_q == $past(strap_word))
        else $error("width default not from straps");
    rsvd_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && req.rd && a == `SPCR_OFF_CMD_STATE) |=> rdata[15:11] == 5'h0)
        else $error("reserved bits nonzero");
    rd_cov_c: cover property (@(posedge clk) clk_en && req.rd && in_mem);
    sticky_cov_c: cover property (@(posedge clk) !soft_reset_n && sts_q[0]);
    mv_cov_c: cover property (@(posedge clk) clk_en && mgmt_wr && in_up);
    db_cov_c: cover property (@(posedge clk) doorbell_irq ##[1:4] !doorbell_irq);

endmodule : spcr_regs

//--- tb/spcr_mgmt_model.sv
/*
 * Management software model: issues one-cycle register requests,
 * read-modify-writes and port moves between member vectors.
 * Assumes the bank takes a request on the rising edge and answers
 * a read one cycle later with rvalid.
 */
module spcr_mgmt_model (
    // Clock.
    input wire logic clk,
    // Request side.
    output spcr_pkg::spcr_req_t req,
    output logic init_wr,
    // Answer side.
    input wire logic [31:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        req = '0;
        init_wr = 1'b0;
    end

    // After release the address and data are inverted so stale values cannot pass.
    task automatic write(input logic [11:0] a, input logic [31:0] d, input logic init);
        @(posedge clk);
        #1;
        req = '{1'b1, 1'b0, a, d};
        init_wr = init;
        @(posedge clk);
        #1;
        req = '{1'b0, 1'b0, ~a, ~d};
        init_wr = 1'b0;
    endtask : write

    task automatic read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        req = '{1'b0, 1'b1, a, ~req.wdata};
        @(posedge clk);
        #1;
        d = (rvalid === 1'b1) ? rdata : 'x;
        req = '{1'b0, 1'b0, ~a, ~req.wdata};
    endtask : read

    task automatic update(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] d;
        read(a, d);
        write(a, (d & ~m) | (v & m), 1'b0);
    endtask : update

    task automatic move_port(input int b, input logic [11:0] src, input logic [11:0] dst);
        logic [31:0] v;
        read(src, v);
        write(src, v & ~(32'h1 << b), 1'b0);
        read(dst, v);
        write(dst, v | (32'h1 << b), 1'b0);
    endtask : move_port

endmodule : spcr_mgmt_model

//--- tb/test_spcr_regs.sv
/*
 * Self-checking bench of the switch port configuration register bank.
 * Assumes spcr_consts.svh on the include path and a 25 MHz clock.
 */
`include "spcr_consts.svh"
module test_spcr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset_n;
    logic soft_reset_n;
    logic clk_en;
    spcr_pkg::spcr_strap_t straps;
    logic mgmt_access;
    spcr_pkg::spcr_req_t req;
    logic init_wr;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] status_set;
    logic sticky_err_set;
    logic irq_pending;
    logic [11:0] port_width_out;
    logic [47:0] lane_owner_first;
    logic [23:0] port_reset_out;
    logic doorbell_irq;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'ha177;
    logic [31:0] d;
    logic [31:0] w;
    localparam logic [11:0] OFFS [12] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h018,
        12'h01c, 12'h020, 12'h028, 12'h030, 12'h034, 12'h038, 12'h3cc};
    localparam logic [31:0] MASKS [12] = '{32'h0, `SPCR_CMD_RW_MASK, 32'h0,
        `SPCR_MISC_RW_MASK, `SPCR_BUS_RW_MASK, `SPCR_IO_RW_MASK, `SPCR_MEM_RW_MASK,
        32'hffff_ffff, `SPCR_IO_UP_RW_MASK, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] FIXED [12] = '{`SPCR_IDENT_RST, `SPCR_CAP_LIST_BIT,
        `SPCR_CLASS_REV_RST, 32'h0001_0000, 32'h0, 32'h0000_0101, 32'h0, 32'h0, 32'h0,
        `SPCR_CAP_POINTER, 32'h0, 32'h0};

    spcr_regs spcr_regs_i (.clk(clk), .reset_n(reset_n), .soft_reset_n(soft_reset_n),
        .clk_en(clk_en), .straps(straps), .mgmt_access(mgmt_access), .req(req),
        .init_wr(init_wr), .rdata(rdata), .rvalid(rvalid), .status_set(status_set),
        .sticky_err_set(sticky_err_set), .irq_pending(irq_pending),
        .port_width_out(port_width_out), .lane_owner_first(lane_owner_first),
        .port_reset_out(port_reset_out), .doorbell_irq(doorbell_irq));
    spcr_mgmt_model spcr_mgmt_model_i (.clk(clk), .req(req), .init_wr(init_wr),
        .rdata(rdata), .rvalid(rvalid));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            print_verdict();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // First lane of every enabled port in one station, lanes in ascending order.
    function automatic logic [15:0] lanes(input logic [1:0] wd);
        case (wd)
            2'b00: return 16'h1111;
            2'b01: return 16'h0001;
            2'b10: return 16'h0101;
            default: return 16'h1101;
        endcase
    endfunction : lanes

    function automatic logic [31:0] vs_def(input logic [1:0] n, input int j);
        case ({n, j[1:0]})
            4'h4: return `SPCR_VS2_MEM0;
            4'h5: return `SPCR_VS2_MEM1;
            4'h8: return `SPCR_VS3_MEM0;
            4'h9: return `SPCR_VS3_MEM1;
            4'ha: return `SPCR_VS3_MEM2;
            4'hc: return `SPCR_VS4_MEM0;
            4'hd: return `SPCR_VS4_MEM1;
            4'he: return `SPCR_VS4_MEM2;
            4'hf: return `SPCR_VS4_MEM3;
            default: return 32'h0;
        endcase
    endfunction : vs_def

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc_wait

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial
    begin
        reset_n = 1'b0;
        soft_reset_n = 1'b1;
        clk_en = 1'b1;
        mgmt_access = 1'b1;
        straps = '0;
        status_set = '0;
        sticky_err_set = 1'b0;
        irq_pending = 1'b0;
        // Every width encoding of station 0 and every switch count, each after a fundamental reset.
        for (int i = 0; i < 4; i++)
        begin
            w = xs();
            straps = {i[1:0], w[1:0], w[3:2], i[1:0]};
            reset_n = 1'b0;
            cyc_wait(6);
            reset_n = 1'b1;
            cyc_wait(3);
            check("port_width", 48'(port_width_out),
                48'({straps.stn5, straps.stn4, 6'h0, straps.stn0}));
            check("lanes", lane_owner_first, {lanes(straps.stn4), lanes(straps.stn5),
                lanes(straps.stn0)});
            for (int j = 0; j < 4; j++)
            begin
                spcr_mgmt_model_i.read(12'h380 + 12'(4 * j), d);
                if (i != 0) check("member", 48'(d), 48'(vs_def(i[1:0], j)));
            end
        end
        for (int k = 0; k < 12; k++)
        begin
            w = xs();
            spcr_mgmt_model_i.write(OFFS[k], w, 1'b0);
            spcr_mgmt_model_i.read(OFFS[k], d);
            check("header", 48'(d),
                48'((w & MASKS[k]) | FIXED[k]));
        end
        spcr_mgmt_model_i.write(12'h000, w, 1'b1);
        spcr_mgmt_model_i.read(12'h000, d);
        check("ident_init", 48'(d), 48'(w));
        irq_pending = 1'b1;
        spcr_mgmt_model_i.update(12'h004, 32'h0000_0400, 32'h0);
        spcr_mgmt_model_i.read(12'h004, d);
        check("irq_shown", 48'(d[19]), 48'(1'b1));
        spcr_mgmt_model_i.update(12'h004, 32'h0000_0400, 32'h0000_0400);
        spcr_mgmt_model_i.read(12'h004, d);
        check("irq_hidden", 48'(d[19]), 48'(1'b0));
        irq_pending = 1'b0;
        status_set = 32'h8800_0000;
        cyc_wait(1);
        status_set = '0;
        spcr_mgmt_model_i.write(12'h004, 32'h0, 1'b0);
        spcr_mgmt_model_i.read(12'h004, d);
        check("w1c_zero", 48'(d & `SPCR_STAT_W1C_MASK), 48'(32'h8800_0000));
        spcr_mgmt_model_i.write(12'h004, 32'h0800_0000, 1'b0);
        spcr_mgmt_model_i.read(12'h004, d);
        check("w1c_one", 48'(d & `SPCR_STAT_W1C_MASK), 48'(32'h8000_0000));
        spcr_mgmt_model_i.write(12'h3c0, 32'h1, 1'b0);
        cyc_wait(1);
        check("bell_set", 48'(doorbell_irq), 48'(1'b1));
        spcr_mgmt_model_i.write(12'h3c4, 32'h1, 1'b0);
        cyc_wait(1);
        check("bell_clr", 48'(doorbell_irq), 48'(1'b0));
        w = xs();
        spcr_mgmt_model_i.write(12'h3c8, w, 1'b0);
        spcr_mgmt_model_i.write(12'h300, 32'h0000_0e02, 1'b0);
        sticky_err_set = 1'b1;
        cyc_wait(1);
        sticky_err_set = 1'b0;
        spcr_mgmt_model_i.write(12'h3a0, 32'h0001_0001, 1'b0);
        cyc_wait(1);
        check("port_rst_on", 48'(port_reset_out), 48'(24'h01_0001));
        spcr_mgmt_model_i.write(12'h3a0, 32'h0, 1'b0);
        cyc_wait(1);
        check("port_rst_off", 48'(port_reset_out), 48'(24'h0));
        soft_reset_n = 1'b0;
        cyc_wait(1);
        soft_reset_n = 1'b1;
        spcr_mgmt_model_i.read(12'h3c8, d);
        check("sticky_rw", 48'(d), 48'(w));
        spcr_mgmt_model_i.read(12'h3d0, d);
        check("sticky_w1c", 48'(d[0]), 48'(1'b1));
        spcr_mgmt_model_i.read(12'h00c, d);
        check("soft_clear", 48'(d), 48'(32'h0001_0000));
        check("width_kept", 48'(port_width_out), 48'(12'he02));
        spcr_mgmt_model_i.write(12'h3d0, 32'h0, 1'b0);
        spcr_mgmt_model_i.read(12'h3d0, d);
        check("w1cs_zero", 48'(d[0]), 48'(1'b1));
        spcr_mgmt_model_i.write(12'h3d0, 32'h1, 1'b0);
        spcr_mgmt_model_i.read(12'h3d0, d);
        check("w1cs_one", 48'(d[0]), 48'(1'b0));
        mgmt_access = 1'b0;
        spcr_mgmt_model_i.write(12'h300, 32'h0, 1'b0);
        spcr_mgmt_model_i.read(12'h300, d);
        check("no_mgmt_rd", 48'(d), 48'(32'h0));
        mgmt_access = 1'b1;
        spcr_mgmt_model_i.read(12'h300, d);
        check("mgmt_rd", 48'(d & `SPCR_PORT_WIDTH_MASK), 48'(32'h0e02));
        clk_en = 1'b0;
        spcr_mgmt_model_i.write(12'h3c8, ~w, 1'b0);
        clk_en = 1'b1;
        spcr_mgmt_model_i.read(12'h3c8, d);
        check("clk_en_off", 48'(d), 48'(w));
        for (int j = 0; j < 4; j++)
        begin
            w = xs();
            spcr_mgmt_model_i.write(12'h360 + 12'(4 * j), w, 1'b0);
            spcr_mgmt_model_i.read(12'h360 + 12'(4 * j), d);
            check("upstream", 48'(d[4:0]), 48'(w[4:0]));
        end
        spcr_mgmt_model_i.move_port(3, 12'h384, 12'h380);
        spcr_mgmt_model_i.read(12'h380, d);
        check("move_dst", 48'(d), 48'(`SPCR_VS4_MEM0 | 32'h8));
        spcr_mgmt_model_i.read(12'h384, d);
        check("move_src", 48'(d), 48'(`SPCR_VS4_MEM1 & ~32'h8));
        print_verdict();
    end

endmodule : test_spcr_regs
